// ==== dv/flash_dev_model.sv ====
module flash_dev_model #(
   parameter int          PROG_NS = 6000,
   parameter logic [6:0]  PROT    = 7'h7f,
   parameter logic [7:0]  MAKER   = 8'h4d,  // Arbitrary value
   parameter logic [7:0]  CONT    = 8'h6e,  // Arbitrary value
   parameter logic [15:0] PART    = 16'h3396 // Arbitrary value
) (
   // Control pins
   input  wire logic        selN,
   input  wire logic        outEnN,
   input  wire logic        wrStrobeN,
   input  wire logic        resetN,
   input  wire logic        hvLevel,
   input  wire logic        widthSel,
   // Address and data
   input  wire logic [18:0] addr,
   input  wire logic [15:0] dq,
   output      logic [15:0] devDq,
   output      logic [15:0] devOe,
   output      logic        readyBusyN,
   output      int          badWr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [256];
   logic [18:0] wa;
   logic [15:0] pd;
   logic [7:0]  pi;
   logic [1:0]  st = 2'h0;
   logic        asel = 1'h0;
   logic        busy = 1'h0;
   logic        tog = 1'h0;
   wire         wrAct = !selN && !wrStrobeN && outEnN;
   wire         rdAct = !selN && !outEnN && resetN;
   initial
   begin
      badWr = 0;
      foreach (mem[i]) mem[i] = {8'(i), ~8'(i)};
   end
   always @(negedge resetN)
   begin
      st = 2'h0;
      asel = 1'h0;
   end
   always @(negedge selN or negedge wrStrobeN) if (!selN && !wrStrobeN && !outEnN) badWr++;
   always @(posedge wrAct) wa = addr;
   always @(negedge wrAct)
   begin : latch_data
      logic [7:0] d;
      d = dq[7:0];
      if (resetN && !busy)
      begin
         if (st == 2'h3 && (wa[18:12] != PROT || hvLevel))
         begin
            pi = wa[7:0];
            pd = widthSel ? dq : {8'hff, dq[7:0]};
            busy = 1'h1;
         end
         if (st == 2'h0 && d == 8'hf0) asel = 1'h0;
         if (st == 2'h2 && wa[10:0] == 11'h555 && d == 8'h90) asel = 1'h1;
         case (st)
            2'h0: st = {1'h0, wa[10:0] == 11'h555 && d == 8'haa};
            2'h1: st = (wa[10:0] == 11'h2aa && d == 8'h55) ? 2'h2 : 2'h0;
            2'h2: st = (wa[10:0] == 11'h555 && d == 8'ha0) ? 2'h3 : 2'h0;
            default: st = 2'h0;
         endcase
      end
   end
   // Embedded program; writes during it are ignored
   always @(posedge busy)
   begin
      #(PROG_NS);
      mem[pi] = mem[pi] & pd;
      busy = 1'h0;
   end
   assign readyBusyN = !busy;
   always @(posedge rdAct) if (busy) tog = !tog;
   always @*
   begin : drive_out
      logic [15:0] w;
      w = mem[addr[7:0]];
      if (busy) w = {8'h00, ~pd[7], tog, 6'h00};
      else if (asel && addr[1:0] == 2'h0) w = {8'h00, addr[8] ? MAKER : CONT};
      else if (asel && addr[1:0] == 2'h1) w = PART;
      else if (asel) w = {15'h0, addr[18:12] == PROT};
      else if (!widthSel) w = {8'h00, dq[15] ? w[15:8] : w[7:0]};
      devDq = w;
      devOe = !rdAct ? 16'h0 : widthSel ? 16'hffff : 16'h00ff;
   end
endmodule : flash_dev_model

// ==== dv/flash_host_tb.sv ====
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errTotal++; \
   $display("ERROR %s exp %h got %h", nm, ex, got); end end
module flash_host_tb import flash_host_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
   logic [31:0] wdata = 32'h0, rdata, s;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, readyBusyN;
   logic        wordMode = 1'h1, hv = 1'h0;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] dqIn, devDq, devOe, q, idle = 16'ha5c3;
   int          errTotal = 0, checked = 0, badWr;
   flash_pins_t pins;
   always #20 clk = ~clk;
   // Undriven lines change every cycle so stale data never passes
   always @(posedge clk) idle <= ~idle;
   assign dqIn = (pins.dqOut & pins.dqOe) | (devDq & devOe & ~pins.dqOe) | (idle & ~pins.dqOe & ~devOe);
   flash_host dut_u (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .pins, .dqIn, .readyBusyN);
   flash_dev_model dev_u (.selN(pins.selN), .outEnN(pins.outEnN), .wrStrobeN(pins.wrStrobeN),
      .resetN(pins.resetN), .hvLevel(pins.highVoltageLevel), .widthSel(pins.widthSel),
      .addr(pins.addr), .dq(dqIn), .devDq, .devOe, .readyBusyN, .badWr);
   function automatic logic [15:0] mk(input logic [7:0] i);
      return {i, ~i};
   endfunction : mk
   task automatic finalReport();
      $display("Comparisons %0d, mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finalReport
   task automatic tmo(input int n, input int lim);
      if (n >= lim)
      begin
         errTotal++;
         finalReport();
      end
   endtask : tmo
   task automatic axiWr(input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < 99);
      r = bresp;
      bready <= 1'h0;
      tmo(n, 99);
   endtask : axiWr
   task automatic axiRd(input logic [4:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         if (arready === 1'h1) arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < 99);
      s = rdata;
      r = rresp;
      rready <= 1'h0;
      tmo(n, 99);
   endtask : axiRd
   task automatic flash(input logic wr, input logic [19:0] a, input logic [15:0] d);
      int n;
      axiWr(REG_ADDR, {12'h0, a});
      axiWr(REG_WDATA, {16'h0, d});
      axiWr(REG_CTRL, {27'h0, 1'h0, hv, wordMode, wr, 1'h1});
      n = 0;
      do
      begin
         axiRd(REG_STATUS);
         n++;
      end while (s[ST_BUSY] !== 1'h0 && n < 30);
      tmo(n, 30);
      axiRd(REG_RDATA);
      q = s[15:0];
   endtask : flash
   task automatic unlock(input logic [7:0] c);
      flash(1'h1, 20'h555, 16'haa);
      flash(1'h1, 20'h2aa, 16'h55);
      flash(1'h1, 20'h555, {8'h0, c});
   endtask : unlock
   task automatic waitReady();
      int n;
      n = 0;
      do
      begin
         axiRd(REG_STATUS);
         n++;
      end while (s[ST_READY] !== 1'h1 && n < 300);
      tmo(n, 300);
   endtask : waitReady
   // Writes during an embedded program are ignored, so wait before unlocking
   task automatic progWord(input logic [19:0] a, input logic [15:0] d);
      waitReady();
      unlock(8'ha0);
      flash(1'h1, a, d);
      waitReady();
      flash(1'h0, a, 16'h0);
   endtask : progWord
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      axiRd(REG_CTRL);
      `CHK("ctrl", CTRL_RESET, s)
      axiRd(5'h14);
      `CHK("rd resp", RESP_SLVERR, r)
      axiWr(5'h18, 32'h0);
      `CHK("wr resp", RESP_SLVERR, r)
      axiWr(REG_CTRL, 32'h0);
      flash(1'h0, 20'h5, 16'h0);
      `CHK("word", mk(8'h5), q)
      wordMode = 1'h0;
      flash(1'h0, 20'h80005, 16'h0);
      `CHK("byte hi", 8'h05, q[7:0])
      flash(1'h0, 20'h5, 16'h0);
      `CHK("byte lo", 8'hfa, q[7:0])
      wordMode = 1'h1;
      unlock(8'h90);
      flash(1'h0, 20'h0, 16'h0);
      `CHK("cont", 16'h006e, q)
      flash(1'h0, 20'h100, 16'h0);
      `CHK("maker", 16'h004d, q)
      flash(1'h0, 20'h1, 16'h0);
      `CHK("part", 16'h3396, q)
      flash(1'h0, 20'h7f002, 16'h0);
      `CHK("prot", 16'h0001, q)
      flash(1'h0, 20'h2, 16'h0);
      `CHK("unprot", 16'h0000, q)
      flash(1'h1, 20'h0, 16'hf0);
      flash(1'h0, 20'h0, 16'h0);
      `CHK("exit id", mk(8'h0), q)
      flash(1'h1, 20'h555, 16'haa);
      flash(1'h1, 20'h123, 16'h55);
      flash(1'h1, 20'h555, 16'h90);
      flash(1'h0, 20'h0, 16'h0);
      `CHK("bad seq", mk(8'h0), q)
      unlock(8'ha0);
      flash(1'h1, 20'h6, 16'h1234);
      axiRd(REG_STATUS);
      `CHK("busy", 1'h0, s[ST_READY])
      flash(1'h0, 20'h6, 16'h0);
      `CHK("poll", 1'h1, q[7])
      flash(1'h0, 20'h6, 16'h0);
      axiRd(REG_STATUS);
      `CHK("toggle", 1'h1, s[ST_TOGGLE])
      `CHK("poll st", 1'h1, s[ST_POLL])
      progWord(20'h6, 16'h1234);
      `CHK("prog", mk(8'h6) & 16'h1234, q)
      progWord(20'h7f003, 16'h0);
      `CHK("locked", mk(8'h3), q)
      hv = 1'h1;
      progWord(20'h7f003, 16'h0);
      `CHK("unlocked", 16'h0, q)
      hv = 1'h0;
      progWord(20'h7f004, 16'h0);
      `CHK("relocked", mk(8'h4), q)
      `CHK("bad writes", 0, badWr)
      finalReport();
   end
endmodule : flash_host_tb

// ==== rtl/flash_host.sv ====
module flash_host
   import flash_host_pkg::*;
(
   // Clock and reset
   input  wire  logic                        clk,
   input  wire  logic                        rst,
   // AXI4-Lite slave
   input  wire  logic [4:0]                  awaddr,
   input  wire  logic                        awvalid,
   output       logic                        awready,
   input  wire  logic [31:0]                 wdata,
   input  wire  logic [3:0]                  wstrb,
   input  wire  logic                        wvalid,
   output       logic                        wready,
   output       logic [1:0]                  bresp,
   output       logic                        bvalid,
   input  wire  logic                        bready,
   input  wire  logic [4:0]                  araddr,
   input  wire  logic                        arvalid,
   output       logic                        arready,
   output       logic [31:0]                 rdata,
   output       logic [1:0]                  rresp,
   output       logic                        rvalid,
   input  wire  logic                        rready,
   // Flash pins
   output       flash_host_pkg::flash_pins_t pins,
   input  wire  logic [15:0]                 dqIn,
   input  wire  logic                        readyBusyN
);
   import flash_host_pkg::*;

   logic [31:0]  ctrl_q, ctrl_d, addr_q, addr_d, wd_q, wd_d, rd_q, rd_d;
   logic         awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [4:0]   awA_q, awA_d;
   logic [31:0]  wD_q, wD_d;
   logic [3:0]   wS_q, wS_d;
   logic         awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0]   bresp_d, rresp_d;
   logic [31:0]  rdata_d;
   cycle_state_t st_q, st_d;
   logic [3:0]   cnt_q, cnt_d;
   flash_pins_t  pins_d;
   logic [15:0]  dqS1_q, dqS2_q;
   logic         rbS1_q, rbS2_q;
   logic         toggleSeen_q, toggleSeen_d;
   logic         lastBit6_q, lastBit6_d;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i])
            old[i*8 +: 8] = nw[i*8 +: 8];
      return old;
   endfunction : merge

   // Two-stage synchronisers on device outputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dqS1_q <= 16'h0000;
         dqS2_q <= 16'h0000;
         rbS1_q <= 1'b1;
         rbS2_q <= 1'b1;
      end
      else
      begin
         dqS1_q <= dqIn;
         dqS2_q <= dqS1_q;
         rbS1_q <= readyBusyN;
         rbS2_q <= rbS1_q;
      end
   end

   always_comb
   begin
      ctrl_d    = ctrl_q;
      addr_d    = addr_q;
      wd_d      = wd_q;
      rd_d      = rd_q;
      awHeld_d  = awHeld_q;
      wHeld_d   = wHeld_q;
      awA_d     = awA_q;
      wD_d      = wD_q;
      wS_d      = wS_q;
      awready_d = 1'b0;
      wready_d  = 1'b0;
      bvalid_d  = bvalid && !bready;
      bresp_d   = bresp;
      arready_d = 1'b0;
      rvalid_d  = rvalid && !rready;
      rresp_d   = rresp;
      rdata_d   = rdata;
      st_d      = st_q;
      cnt_d     = cnt_q;
      pins_d    = pins;
      toggleSeen_d = toggleSeen_q;
      lastBit6_d   = lastBit6_q;
      if (awvalid && !awHeld_q && !awready)
      begin
         awready_d = 1'b1;
         awHeld_d  = 1'b1;
         awA_d     = awaddr;
      end
      if (wvalid && !wHeld_q && !wready)
      begin
         wready_d = 1'b1;
         wHeld_d  = 1'b1;
         wD_d     = wdata;
         wS_d     = wstrb;
      end
      if (awHeld_q && wHeld_q && !bvalid)
      begin
         awHeld_d = 1'b0;
         wHeld_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = RESP_OKAY;
         unique case (awA_q)
            REG_CTRL:  ctrl_d = merge(ctrl_q, wD_q, wS_q);
            REG_ADDR:  addr_d = merge(addr_q, wD_q, wS_q);
            REG_WDATA: wd_d   = merge(wd_q, wD_q, wS_q);
            REG_STATUS, REG_RDATA: ;
            default:   bresp_d = RESP_SLVERR;
         endcase
      end
      if (arvalid && !arready && !rvalid)
      begin
         arready_d = 1'b1;
         rvalid_d  = 1'b1;
         rresp_d   = RESP_OKAY;
         unique case (araddr)
            REG_CTRL:   rdata_d = ctrl_q;
            REG_ADDR:   rdata_d = addr_q;
            REG_WDATA:  rdata_d = wd_q;
            REG_STATUS: rdata_d = {27'h0, rd_q[5], toggleSeen_q, rd_q[7],
                                   rbS2_q, st_q != S_IDLE};
            REG_RDATA:  rdata_d = rd_q;
            default:
            begin
               rdata_d = 32'h0;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
      pins_d.resetN           = !ctrl_q[CTRL_RST];
      pins_d.highVoltageLevel = ctrl_q[CTRL_HV];
      pins_d.widthSel         = ctrl_q[CTRL_WORD];
      unique case (st_q)
         S_IDLE:
         begin
            pins_d.selN      = 1'b1;
            pins_d.outEnN    = 1'b1;
            pins_d.wrStrobeN = 1'b1;
            pins_d.dqOe      = 16'h0000;
            if (ctrl_q[CTRL_GO])
            begin
               ctrl_d[CTRL_GO] = 1'b0;
               pins_d.addr     = addr_q[18:0];
               // Byte mode: line 15 carries the top address bit, addr_q[19]
               pins_d.dqOut    = ctrl_q[CTRL_WORD] ? wd_q[15:0]
                                 : {addr_q[19], 7'h00, wd_q[7:0]};
               pins_d.dqOe     = ctrl_q[CTRL_WRITE]
                                 ? (ctrl_q[CTRL_WORD] ? 16'hffff : 16'h80ff)
                                 : (ctrl_q[CTRL_WORD] ? 16'h0000 : 16'h8000);
               pins_d.selN     = 1'b0;
               st_d            = S_SETUP;
               cnt_d           = SETUP_CYC;
            end
         end
         S_SETUP:
         begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               // Output enable held high on writes so never read as a read
               if (ctrl_q[CTRL_WRITE])
                  pins_d.wrStrobeN = 1'b0;
               else
                  pins_d.outEnN = 1'b0;
               // Capture must see data that already passed both input flops
               cnt_d = ctrl_q[CTRL_WRITE] ? STROBE_CYC : ACCESS_CYC + SYNC_CYC;
               st_d  = S_STROBE;
            end
         end
         S_STROBE:
         begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               if (!ctrl_q[CTRL_WRITE])
               begin
                  rd_d         = {16'h0, ctrl_q[CTRL_WORD] ? dqS2_q : {8'h00, dqS2_q[7:0]}};
                  lastBit6_d   = dqS2_q[6];
                  toggleSeen_d = dqS2_q[6] != lastBit6_q;
               end
               pins_d.wrStrobeN = 1'b1;
               pins_d.outEnN    = 1'b1;
               cnt_d            = HOLD_CYC;
               st_d             = S_HOLD;
            end
         end
         S_HOLD:
         begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               pins_d.selN = 1'b1;
               pins_d.dqOe = 16'h0000;
               st_d        = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= CTRL_RESET;
         addr_q <= 32'h0;
         wd_q   <= 32'h0;
         rd_q   <= 32'h0;
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awA_q  <= 5'h0;
         wD_q   <= 32'h0;
         wS_q   <= 4'h0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rresp   <= 2'h0;
         rdata   <= 32'h0;
         st_q    <= S_IDLE;
         cnt_q   <= 4'h0;
         pins    <= '{selN: 1'b1, outEnN: 1'b1, wrStrobeN: 1'b1, resetN: 1'b0,
                      highVoltageLevel: 1'b0, widthSel: 1'b1, addr: 19'h0,
                      dqOut: 16'h0, dqOe: 16'h0};
         toggleSeen_q <= 1'b0;
         lastBit6_q   <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         wd_q   <= wd_d;
         rd_q   <= rd_d;
         awHeld_q <= awHeld_d;
         wHeld_q  <= wHeld_d;
         awA_q  <= awA_d;
         wD_q   <= wD_d;
         wS_q   <= wS_d;
         awready <= awready_d;
         wready  <= wready_d;
         bvalid  <= bvalid_d;
         bresp   <= bresp_d;
         arready <= arready_d;
         rvalid  <= rvalid_d;
         rresp   <= rresp_d;
         rdata   <= rdata_d;
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         pins    <= pins_d;
         toggleSeen_q <= toggleSeen_d;
         lastBit6_q   <= lastBit6_d;
      end
   end

   chk_write_oe_high : assert property (@(posedge clk) disable iff (rst)
      !pins.wrStrobeN |-> pins.outEnN && !pins.selN)
      else $error("write strobe low without output-enable high");
   sequence strobePulse;
      !pins.wrStrobeN [*2] ##1 pins.wrStrobeN;
   endsequence : strobePulse
   chk_strobe_length : assert property (@(posedge clk) disable iff (rst)
      $fell(pins.wrStrobeN) |-> strobePulse)
      else $error("write strobe width wrong");
   chk_data_held : assert property (@(posedge clk) disable iff (rst)
      $rose(pins.wrStrobeN) |-> $stable(pins.dqOut) && !pins.selN)
      else $error("data changed at write strobe release");
   chk_idle_deselect : assert property (@(posedge clk) disable iff (rst)
      st_q == S_IDLE && $past(st_q) == S_IDLE |-> pins.selN)
      else $error("chip select low while idle");
   chk_byte_lanes : assert property (@(posedge clk) disable iff (rst)
      !pins.widthSel && !pins.selN |-> pins.dqOe[14:8] == 7'h00)
      else $error("upper lines driven in byte mode");
   chk_word_lanes : assert property (@(posedge clk) disable iff (rst)
      pins.widthSel && !pins.wrStrobeN |-> pins.dqOe == 16'hffff)
      else $error("word write without sixteen lines");
   chk_no_contention : assert property (@(posedge clk) disable iff (rst)
      !pins.outEnN |-> pins.dqOe[7:0] == 8'h00)
      else $error("host drives data during read");
   chk_cycle_ends : assert property (@(posedge clk) disable iff (rst)
      $fell(pins.selN) |-> ##[4:7] pins.selN)
      else $error("bus cycle length wrong");
endmodule : flash_host

// ==== rtl/flash_host_pkg.sv ====
// Overview of operation
// - Host writes reset after timeout or identification; the host has no timeout, and only the testbench writes f0 after identification
// - Command identification keeps address bit 9 normal
// - Write: select and strobe low, output-enable high
// - Byte mode low lines, word mode sixteen
// - Protect other sectors before unprotecting one
// - Program and erase need unlock cycles
package flash_host_pkg;
   localparam int          CLK_NS        = 40;
   // Phase lengths in ns, rounded up to whole cycles
   localparam int          SETUP_NS      = 40;
   localparam int          STROBE_NS     = 80;
   localparam int          ACCESS_NS     = 120;
   localparam int          HOLD_NS       = 40;
   localparam logic [3:0]  SETUP_CYC     = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  STROBE_CYC    = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  ACCESS_CYC    = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  HOLD_CYC      = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
   // Extra read cycles while data crosses the two input flops
   localparam logic [3:0]  SYNC_CYC      = 4'h2;
   // Register byte offsets
   localparam logic [4:0]  REG_CTRL      = 5'h00;
   localparam logic [4:0]  REG_ADDR      = 5'h04;
   localparam logic [4:0]  REG_WDATA     = 5'h08;
   localparam logic [4:0]  REG_STATUS    = 5'h0c;
   localparam logic [4:0]  REG_RDATA     = 5'h10;
   // Control fields
   localparam int          CTRL_GO       = 0;
   localparam int          CTRL_WRITE    = 1;
   localparam int          CTRL_WORD     = 2;
   localparam int          CTRL_HV       = 3;
   localparam int          CTRL_RST      = 4;
   // Status fields
   localparam int          ST_BUSY       = 0;
   localparam int          ST_READY      = 1;
   localparam int          ST_POLL       = 2;
   localparam int          ST_TOGGLE     = 3;
   localparam int          ST_TIMEOUT    = 4;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0014;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic        selN;
      logic        outEnN;
      logic        wrStrobeN;
      logic        resetN;
      logic        highVoltageLevel;
      logic        widthSel;
      logic [18:0] addr;
      logic [15:0] dqOut;
      logic [15:0] dqOe;
   } flash_pins_t;

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} cycle_state_t;
endpackage : flash_host_pkg
